/* File: pss_pkg.sv */
/*
  Constants, types and decode functions shared by the PWM shutdown and
  start-up sequencer. Assumes a single 100 MHz clock domain.
*/
package pss_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [7:0] ADDR_SD_SET = 8'h19;
  localparam logic [7:0] ADDR_RAMP   = 8'h1A;
  localparam logic [7:0] ADDR_TRIM   = 8'h1B;
  localparam logic [7:0] ADDR_RETRY  = 8'h1C;

  localparam logic [7:0] SD_SET_RST  = 8'h30;
  localparam logic [7:0] RAMP_RST    = 8'h0F;
  localparam logic       TRIM_SEL_RST = 1'b1;
  localparam logic [3:0] RETRY_RST   = 4'h2;
  localparam logic [3:0] MASK_ALL    = 4'hF;

  localparam int RAMP_DIS_BIT  = 7;
  localparam int TRIM_DONE_BIT = 6;
  localparam int TRIM_SEL_BIT  = 1;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 100000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int TRIM_TIME_NS  = 640;
  localparam int TRIM_CYC_I    = (TRIM_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [6:0] TRIM_CYC = 7'(TRIM_CYC_I);
  localparam int TMR_W = 18;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pss_bus_t;

  typedef enum logic [2:0] {
    ST_SHUT, ST_RAMP_UP, ST_RUN, ST_RAMP_DOWN, ST_FAULT
  } pss_state_t;

  // soft ramp length in 0.1 ms ticks; zero means no interval
  function automatic logic [TMR_W-1:0] ramp_ticks(input logic [4:0] code);
    case (code)
      5'h08: ramp_ticks = 18'd165;
      5'h09: ramp_ticks = 18'd239;
      5'h0A: ramp_ticks = 18'd314;
      5'h0B: ramp_ticks = 18'd404;
      5'h0C: ramp_ticks = 18'd539;
      5'h0D: ramp_ticks = 18'd703;
      5'h0E: ramp_ticks = 18'd942;
      5'h0F: ramp_ticks = 18'd1257;
      5'h10: ramp_ticks = 18'd1646;
      5'h11: ramp_ticks = 18'd2394;
      5'h12: ramp_ticks = 18'd3142;
      5'h13: ramp_ticks = 18'd4039;
      5'h14: ramp_ticks = 18'd5386;
      5'h15: ramp_ticks = 18'd7031;
      5'h16: ramp_ticks = 18'd9425;
      5'h17: ramp_ticks = 18'd12566;
      5'h18: ramp_ticks = 18'd17281;
      5'h19: ramp_ticks = 18'd25136;
      5'h1A: ramp_ticks = 18'd32991;
      5'h1B: ramp_ticks = 18'd42417;
      5'h1C: ramp_ticks = 18'd56556;
      5'h1D: ramp_ticks = 18'd73837;
      5'h1E: ramp_ticks = 18'd98973;
      5'h1F: ramp_ticks = 18'd131964;
      default: ramp_ticks = 18'd0;
    endcase
  endfunction : ramp_ticks

  // power-stage retry wait in 0.1 ms ticks
  function automatic logic [TMR_W-1:0] retry_ticks(input logic [3:0] code);
    case (code)
      4'h2: retry_ticks = 18'd2990;
      4'h3: retry_ticks = 18'd4490;
      4'h4: retry_ticks = 18'd5980;
      4'h5: retry_ticks = 18'd7480;
      4'h6: retry_ticks = 18'd8980;
      4'h7: retry_ticks = 18'd10470;
      4'h8: retry_ticks = 18'd11970;
      4'h9: retry_ticks = 18'd13460;
      default: retry_ticks = 18'd14960;
    endcase
  endfunction : retry_ticks

endpackage : pss_pkg

/* File: pss_tick_div.sv */
/*
  Divider that emits a one-cycle enable every DIV clocks.
  Assumes DIV is between 2 and 65535.
*/
`timescale 1ns/1ps
module pss_tick_div
#(
  parameter int DIV = 10000
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // enable
  output logic      tick
);

  logic [15:0] cnt_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 16'h0000;
      tick   <= 1'b0;
    end
    else if (cnt_ff == 16'(DIV - 1))
    begin
      cnt_ff <= 16'h0000;
      tick   <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 16'h0001;
      tick   <= 1'b0;
    end
  end

endmodule : pss_tick_div

/* File: pss_tick_timer.sv */
/*
  Down counter that runs on an enable pulse and flags its end once.
  Assumes load values are never zero.
*/
`timescale 1ns/1ps
module pss_tick_timer
  import pss_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             tick,
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] load_val,
  // status
  output logic [TMR_W-1:0]      cnt,
  output logic                  done
);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt  <= '0;
      done <= 1'b0;
    end
    else if (load)
    begin
      cnt  <= load_val;
      done <= 1'b0;
    end
    else if (tick && cnt != '0)
    begin
      cnt  <= cnt - 18'd1;
      done <= (cnt == 18'd1);
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule : pss_tick_timer

/* File: pss_sequencer.sv */
/*
  PWM shutdown and start-up sequencer: channel shutdown set, soft ramp
  timing, oscillator trim control and power-stage fault retry, with a
  byte register port. Assumes the shutdown command, shutdown behaviour
  bit and power-stage error come from logic on clk; the power-down pin
  is asynchronous.
*/
`timescale 1ns/1ps
// Operation
// R1 - software writes shutdown set 0x30 for bridge-tied, 0x3A for parallel
// R2 - with behaviour bit 0, masked channels stay stopped leaving shutdown
// R3 - mask bits 3..0 map to channels 4..1; 1 means in shutdown set
// R4 - 50% duty ramp on shutdown entry/exit or pin change, timer enabled
// R5 - period code selects none for 00xxx, else 16.5 ms to 13196.4 ms
// R6 - internal oscillator trim engine supports clock rate detection; here trim is only a fixed 64-cycle count
// R7 - writing 0x00 to trim register selects the factory trim
// R8 - software starts a trim after each reset before relying on it
// R9 - trim register bit 6 reads 0 until trim finishes, then 1
// R10 - trim select bit resets to 1; writing 0 selects factory trim
// R11 - power-stage error resets stage, halts PWM, waits retry period
// R12 - retry code 2 gives 299 ms, up to 1346 ms, 10 and above 1496 ms
// R13 - software writes only non-reserved retry values
// R14 - retry register takes exactly one write after each reset
// R15 - disabled timer or no-interval code skips the ramp entirely
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire pss_bus_t   bus,
  output logic [7:0]      reg_rdata,
  // system control
  input  wire logic       all_ch_shutdown,
  input  wire logic       sd_behaviour,
  input  wire logic       power_down_pin_n,
  input  wire logic       power_stage_err,
  // channel control
  output logic [3:0]      ch_run,
  output logic            ch_half_duty,
  output logic            power_stage_rst,
  // oscillator
  output logic            osc_factory_trim,
  output logic            osc_trim_done
);

  // ********************************************************************
  // declarations
  // ********************************************************************
  pss_state_t       state_ff;
  pss_state_t       nxt_state;
  logic [7:0]       shutdown_set_ff;
  logic             ramp_dis_ff;
  logic [4:0]       ramp_code_ff;
  logic             trim_sel_ff;
  logic             trim_done_ff;
  logic [6:0]       trim_cnt_ff;
  logic [3:0]       retry_ff;
  logic             retry_locked_ff;
  logic [3:0]       run_mask_ff;
  logic [1:0]       pdn_sync_ff;
  logic [7:0]       rdata_ff;
  logic [3:0]       ch_run_ff;
  logic             half_duty_ff;
  logic             ps_rst_ff;
  logic             factory_ff;
  logic             tick;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic [TMR_W-1:0] tmr_cnt;
  logic             tmr_done;
  logic             sd_req;
  logic             ramp_on;
  logic             wr_trim;
  logic             wr_retry_ok;
  logic [7:0]       rd_val;

  assign reg_rdata        = rdata_ff;
  assign ch_run           = ch_run_ff;
  assign ch_half_duty     = half_duty_ff;
  assign power_stage_rst  = ps_rst_ff;
  assign osc_factory_trim = factory_ff;
  assign osc_trim_done    = trim_done_ff;

  // ********************************************************************
  // pin synchroniser
  // ********************************************************************
  // pin resets to the powered-down level so nothing starts early
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pdn_sync_ff <= 2'b00;
    else
      pdn_sync_ff <= {pdn_sync_ff[0], power_down_pin_n};
  end

  // either source of shutdown counts; with ramp_on set, each edge of it outside ST_RAMP_DOWN and ST_FAULT starts a ramp
  assign sd_req  = all_ch_shutdown | ~pdn_sync_ff[1];
  assign ramp_on = ~ramp_dis_ff && (ramp_ticks(ramp_code_ff) != '0);

  // ********************************************************************
  // timebase and timer
  // ********************************************************************
  pss_tick_div #(
    .DIV (TICK_CYCLES)
  ) u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // one timer serves ramps and retry waits; they never overlap
  pss_tick_timer u_tmr (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (tick),
    .load     (tmr_load),
    .load_val (tmr_val),
    .cnt      (tmr_cnt),
    .done     (tmr_done)
  );

  // ********************************************************************
  // register writes
  // ********************************************************************
  assign wr_trim     = bus.wr && (bus.addr == ADDR_TRIM);
  assign wr_retry_ok = bus.wr && (bus.addr == ADDR_RETRY) &&
                       !retry_locked_ff && (bus.wdata[7:4] == 4'h0) &&
                       (bus.wdata[3:1] != 3'h0);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shutdown_set_ff <= SD_SET_RST;
    else if (bus.wr && bus.addr == ADDR_SD_SET)
      shutdown_set_ff <= bus.wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ramp_dis_ff  <= RAMP_RST[RAMP_DIS_BIT];
      ramp_code_ff <= RAMP_RST[4:0];
    end
    else if (bus.wr && bus.addr == ADDR_RAMP)
    begin
      ramp_dis_ff  <= bus.wdata[RAMP_DIS_BIT];
      ramp_code_ff <= bus.wdata[4:0];
    end
  end

  // reserved retry codes are dropped without using up the one write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      retry_ff        <= RETRY_RST;
      retry_locked_ff <= 1'b0;
    end
    else if (wr_retry_ok)
    begin
      retry_ff        <= bus.wdata[3:0]; // see R14
      retry_locked_ff <= 1'b1;           // see R14
    end
  end

  // ********************************************************************
  // oscillator trim
  // ********************************************************************
  // a write restarts trim; the engine stays idle until then
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_sel_ff  <= TRIM_SEL_RST;                  // see R10
      factory_ff   <= ~TRIM_SEL_RST;
      trim_cnt_ff  <= 7'h00;
      trim_done_ff <= 1'b0;
    end
    else if (wr_trim)
    begin
      trim_sel_ff  <= bus.wdata[TRIM_SEL_BIT];       // see R10
      factory_ff   <= ~bus.wdata[TRIM_SEL_BIT];      // see R7
      trim_cnt_ff  <= TRIM_CYC;                      // see R6
      trim_done_ff <= 1'b0;
    end
    else if (trim_cnt_ff != 7'h00)
    begin
      trim_cnt_ff  <= trim_cnt_ff - 7'h01;
      trim_done_ff <= (trim_cnt_ff == 7'h01);        // see R9
    end
  end

  // ********************************************************************
  // register reads
  // ********************************************************************
  always_comb
  begin
    rd_val = 8'h00;
    case (bus.addr)
      ADDR_SD_SET: rd_val = shutdown_set_ff;
      ADDR_RAMP:   rd_val = {ramp_dis_ff, 2'b00, ramp_code_ff};
      ADDR_TRIM:   rd_val = {1'b0, trim_done_ff, 4'h0,
                             trim_sel_ff, 1'b0};     // see R9
      ADDR_RETRY:  rd_val = {4'h0, retry_ff};
      default:     rd_val = 8'h00;
    endcase
  end

  // data stand for the cycle after the read strobe only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (bus.rd)
      rdata_ff <= rd_val;
    else
      rdata_ff <= 8'h00;
  end

  // ********************************************************************
  // sequencer
  // ********************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_val   = ramp_ticks(ramp_code_ff);                // see R5
    case (state_ff)
      ST_SHUT:
        if (!sd_req)
        begin
          nxt_state = ramp_on ? ST_RAMP_UP : ST_RUN;     // see R4 R15
          tmr_load  = ramp_on;
        end
      ST_RAMP_UP:
        if (sd_req)
        begin
          nxt_state = ramp_on ? ST_RAMP_DOWN : ST_SHUT;  // see R15
          tmr_load  = ramp_on;
        end
        else if (tmr_done)
          nxt_state = ST_RUN;
      ST_RUN:
        if (sd_req)
        begin
          nxt_state = ramp_on ? ST_RAMP_DOWN : ST_SHUT;  // see R4 R15
          tmr_load  = ramp_on;
        end
      ST_RAMP_DOWN:
        if (tmr_done)
          nxt_state = ST_SHUT;
      ST_FAULT:
        if (tmr_done)
          nxt_state = sd_req ? ST_SHUT : ST_RUN;         // see R11
      default:
        nxt_state = ST_SHUT;
    endcase
    // a stage error overrides any other move while the stage is live
    if (power_stage_err && state_ff != ST_SHUT && state_ff != ST_FAULT)
    begin
      nxt_state = ST_FAULT;                              // see R11
      tmr_load  = 1'b1;
      tmr_val   = retry_ticks(retry_ff);                 // see R12
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_SHUT;
    else
      state_ff <= nxt_state;
  end

  // set of channels that restart is fixed at shutdown exit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_mask_ff <= MASK_ALL;
    else if (state_ff == ST_SHUT && nxt_state != ST_SHUT)
      run_mask_ff <= sd_behaviour ? MASK_ALL
                                  : ~shutdown_set_ff[3:0]; // see R2 R3
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch_run_ff    <= 4'h0;
      half_duty_ff <= 1'b0;
      ps_rst_ff    <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_RUN:       ch_run_ff <= run_mask_ff;           // see R3
        ST_RAMP_UP:   ch_run_ff <= run_mask_ff;
        ST_RAMP_DOWN: ch_run_ff <= run_mask_ff;
        default:      ch_run_ff <= 4'h0;                  // see R11
      endcase
      half_duty_ff <= (state_ff == ST_RAMP_UP) ||
                      (state_ff == ST_RAMP_DOWN);         // see R4
      ps_rst_ff    <= (state_ff == ST_FAULT);             // see R11
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_MASK_AT_EXIT: assert property ( // see R2
    (state_ff == ST_SHUT && nxt_state != ST_SHUT && !sd_behaviour)
    |=> (run_mask_ff == ~$past(shutdown_set_ff[3:0])))
    else $error("restart set does not follow shutdown set");

  AST_CH_MAP: assert property ( // see R3
    (state_ff == ST_RUN) |=> (ch_run_ff == run_mask_ff))
    else $error("running channels differ from restart set");

  AST_RAMP_ENTRY: assert property ( // see R4
    (state_ff == ST_RUN && sd_req && ramp_on && !power_stage_err)
    |=> (state_ff == ST_RAMP_DOWN) ##1 ch_half_duty)
    else $error("shutdown entry gave no half duty interval");

  AST_RAMP_LEN: assert property ( // see R5
    (state_ff == ST_RUN && sd_req && !ramp_dis_ff && !power_stage_err &&
     ramp_code_ff == 5'h08) |=> (tmr_cnt == 18'd165))
    else $error("shortest ramp length wrong");

  AST_NO_RAMP: assert property ( // see R15
    (state_ff == ST_RUN && sd_req && !ramp_on && !power_stage_err)
    |=> (state_ff == ST_SHUT) ##1 (!ch_half_duty && ch_run == 4'h0))
    else $error("ramp taken although disabled");

  AST_FACTORY: assert property ( // see R7 R10
    (wr_trim && bus.wdata == 8'h00)
    |=> (osc_factory_trim && !trim_sel_ff))
    else $error("zero write did not select factory trim");

  AST_TRIM_BUSY: assert property ( // see R9
    wr_trim ##1 !wr_trim [*8] |-> !osc_trim_done)
    else $error("trim done too early");

  AST_TRIM_DONE: assert property ( // see R9 R6
    (trim_cnt_ff == 7'h01 && !wr_trim) |=> osc_trim_done)
    else $error("trim done not flagged");

  AST_FAULT: assert property ( // see R11
    (power_stage_err && state_ff == ST_RUN) |=> (state_ff == ST_FAULT)
    ##1 (power_stage_rst && ch_run == 4'h0 && !ch_half_duty))
    else $error("fault did not halt the stage");

  AST_RETRY_LOAD: assert property ( // see R12
    (power_stage_err && state_ff == ST_RUN && retry_ff == 4'h2)
    |=> (tmr_cnt == 18'd2990))
    else $error("default retry wait wrong");

  AST_ONCE: assert property ( // see R14
    retry_locked_ff |=> $stable(retry_ff))
    else $error("retry register changed after first write");

endmodule : pss_sequencer

/* File: tb_top.sv */
/*
  Self-checking bench for the PWM shutdown and start-up sequencer:
  register tasks, shutdown set, soft ramp, trim and fault retry.
  Assumes pss_pkg and the design files are compiled before it.
*/
`timescale 1ns/1ps
module tb_top
  import pss_pkg::*;
  ;
  // ******************************************************************
  // setup
  // ******************************************************************
  // short tick keeps the longest retry wait near 30k cycles
  localparam int TC = 2;
  logic       clk, rst_n, all_ch_shutdown, sd_behaviour;
  logic       power_down_pin_n, power_stage_err;
  pss_bus_t   bus;
  logic [7:0] reg_rdata;
  logic [3:0] ch_run;
  logic       ch_half_duty, power_stage_rst, osc_factory_trim, osc_trim_done;
  int         mismatches, tests_run, hd_cnt, rs_cnt, i;

  pss_sequencer #(.TICK_CYCLES(TC)) uut
  (
    .clk              (clk),
    .rst_n            (rst_n),
    .bus              (bus),
    .reg_rdata        (reg_rdata),
    .all_ch_shutdown  (all_ch_shutdown),
    .sd_behaviour     (sd_behaviour),
    .power_down_pin_n (power_down_pin_n),
    .power_stage_err  (power_stage_err),
    .ch_run           (ch_run),
    .ch_half_duty     (ch_half_duty),
    .power_stage_rst  (power_stage_rst),
    .osc_factory_trim (osc_factory_trim),
    .osc_trim_done    (osc_trim_done)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // cycles spent in the half-duty ramp and in power-stage reset
  always @(posedge clk)
  begin
    if (ch_half_duty === 1'b1) hd_cnt++;
    if (power_stage_rst === 1'b1) rs_cnt++;
  end

  // ******************************************************************
  // tasks
  // ******************************************************************
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      mismatches++;
    end
  endtask : chk

  task automatic rng(input string what, input int seen, input int lo,
                     input int hi);
    chk(what, 32'(seen), (seen >= lo && seen <= hi) ? 32'(seen) : 32'(lo));
  endtask : rng

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(what, 32'(reg_rdata), 32'(exp));
  endtask : rd

  // waits for settled channels with no ramp running
  task automatic wait_run(input logic [3:0] exp, input int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      #1;
      if (ch_run === exp && ch_half_duty === 1'b0) break;
    end
    if (n == lim)
    begin
      $display("unexpected ch_run: expected %h, seen %h", exp, ch_run);
      mismatches++;
      wrap_up();
    end
  endtask : wait_run

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // ******************************************************************
  // sequence
  // ******************************************************************
  initial
  begin
    mismatches = 0;
    tests_run = 0;
    hd_cnt = 0;
    rs_cnt = 0;
    rst_n = 1'b0;
    bus = '0;
    all_ch_shutdown = 1'b1;
    sd_behaviour = 1'b0;
    power_down_pin_n = 1'b1;
    power_stage_err = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_SD_SET, 8'h30, "sd_set reset");
    rd(ADDR_RAMP, 8'h0F, "ramp reset");
    rd(ADDR_TRIM, 8'h02, "trim reset");
    rd(ADDR_RETRY, 8'h02, "retry reset");
    rd(8'h00, 8'h00, "unmapped");
    chk("factory trim", osc_factory_trim, 1'b0);
    $display("test registers done");

    wr(ADDR_TRIM, 8'h00);
    #1;
    chk("factory trim", osc_factory_trim, 1'b1);
    rd(ADDR_TRIM, 8'h00, "trim busy");
    for (i = 0; i < 80 && osc_trim_done !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("trim done", osc_trim_done, 1'b1);
    if (osc_trim_done !== 1'b1) wrap_up();
    rd(ADDR_TRIM, 8'h40, "trim finished");
    $display("test trim done");

    wr(ADDR_RAMP, 8'h80);
    wr(ADDR_SD_SET, 8'h3A);
    hd_cnt = 0;
    all_ch_shutdown <= 1'b0;
    wait_run(4'h5, 200);
    chk("no ramp", 32'(hd_cnt), 0);
    sd_behaviour <= 1'b1;
    wr(ADDR_RAMP, 8'h07);
    all_ch_shutdown <= 1'b1;
    wait_run(4'h0, 200);
    all_ch_shutdown <= 1'b0;
    wait_run(4'hF, 200);
    chk("no interval", 32'(hd_cnt), 0);
    $display("test shutdown set done");

    wr(ADDR_RAMP, 8'h08);
    hd_cnt = 0;
    all_ch_shutdown <= 1'b1;
    wait_run(4'h0, 1000);
    rng("ramp down", hd_cnt, 164 * TC, 165 * TC + 3);
    hd_cnt = 0;
    all_ch_shutdown <= 1'b0;
    wait_run(4'hF, 1000);
    rng("ramp up", hd_cnt, 164 * TC, 165 * TC + 3);
    hd_cnt = 0;
    power_down_pin_n <= 1'b0;
    wait_run(4'h0, 1000);
    rng("pin ramp", hd_cnt, 164 * TC, 165 * TC + 3);
    power_down_pin_n <= 1'b1;
    wait_run(4'hF, 1000);
    $display("test ramp done");

    rs_cnt = 0;
    @(posedge clk);
    power_stage_err <= 1'b1;
    @(posedge clk);
    power_stage_err <= 1'b0;
    wait_run(4'hF, 8000);
    chk("stage released", power_stage_rst, 1'b0);
    rng("default retry", rs_cnt, 2989 * TC, 2990 * TC + 3);
    $display("test default retry done");

    wr(ADDR_RETRY, 8'h01);
    rd(ADDR_RETRY, 8'h02, "retry reserved");
    wr(ADDR_RETRY, 8'hF3);
    rd(ADDR_RETRY, 8'h02, "retry high bits");
    wr(ADDR_RETRY, 8'h0A);
    rd(ADDR_RETRY, 8'h0A, "retry first");
    wr(ADDR_RETRY, 8'h03);
    rd(ADDR_RETRY, 8'h0A, "retry locked");
    rs_cnt = 0;
    @(posedge clk);
    power_stage_err <= 1'b1;
    @(posedge clk);
    power_stage_err <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("stage reset", power_stage_rst, 1'b1);
    chk("pwm halted", ch_run, 4'h0);
    wait_run(4'hF, 40000);
    chk("stage released", power_stage_rst, 1'b0);
    rng("retry wait", rs_cnt, 14959 * TC, 14960 * TC + 3);
    $display("test retry done");

    do_reset();
    rd(ADDR_RETRY, 8'h02, "retry rearmed");
    wr(ADDR_RETRY, 8'h09);
    rd(ADDR_RETRY, 8'h09, "retry after reset");
    rd(ADDR_SD_SET, 8'h30, "sd_set rearmed");
    rd(ADDR_TRIM, 8'h02, "trim rearmed");
    $display("test second reset done");
    wrap_up();
  end

endmodule : tb_top
